// ==== design/scn_pkg.sv ====
// Purpose: Shared constants for status-change notify ends
// Assumes: 40 MHz system clock
// Notes: Card register offsets are byte offsets from the base
package scn_pkg;
  // Card register byte offsets
  localparam logic [3:0] SCN_EVT_OFS = 4'h0;
  localparam logic [3:0] SCN_MSK_OFS = 4'h4;
  localparam logic [3:0] SCN_PST_OFS = 4'h8;
  localparam logic [3:0] SCN_FRC_OFS = 4'hc;
  // Field positions
  localparam int SCN_WP_BIT = 0;
  localparam int SCN_RDY_BIT = 1;
  localparam int SCN_BVD2_BIT = 2;
  localparam int SCN_BVD1_BIT = 3;
  localparam int SCN_GENERAL_WAKE_FIELD_BIT = 4;
  localparam int SCN_WKEN_BIT = 14;
  localparam int SCN_INTERRUPT_REQUEST_FIELD_BIT = 15;
  // Field groups
  localparam logic [31:0] SCN_EVT_FIELDS = 32'h0000_801f;
  localparam logic [31:0] SCN_LVL_FIELDS = 32'h0000_000f;
  localparam logic [31:0] SCN_IMPL_DEF = 32'h0000_c01f;
  localparam logic [31:0] SCN_REG_RESET = 32'h0000_0000;
  // Timing
  localparam int SCN_CLK_HZ = 40_000_000;
  localparam int SCN_WAKE_MIN_US = 1000;
  localparam int SCN_WAKE_CYC =
    SCN_WAKE_MIN_US * (SCN_CLK_HZ / 1_000_000);
  localparam int SCN_RST_CYC = 16;
  // Socket register byte offsets
  localparam logic [7:0] SCN_H_CTRL = 8'h00;
  localparam logic [7:0] SCN_H_STAT = 8'h04;
  localparam logic [7:0] SCN_H_CARD = 8'h10;
  localparam int SCN_CTRL_PWR = 0;
  localparam int SCN_CTRL_AUTO = 1;
  localparam logic [1:0] SCN_OKAY = 2'b00;
  localparam logic [1:0] SCN_SLVERR = 2'b10;

  // Write-one-to-clear where a set in the same cycle wins
  function automatic logic [31:0] scn_w1c(input logic [31:0] old,
    input logic [31:0] set, input logic [31:0] clr);
    return (old & ~clr) | set;
  endfunction
endpackage

// ==== design/scn_if.sv ====
// Purpose: Link between card and socket ends
// Assumes: Both ends on i_sys_clk
// Notes: Status line is asynchronous to the register strobes
`timescale 1ns/1ps
interface scn_if;
  logic card_status_change_line;
  logic card_reset_line_n;
  logic power_on;
  logic req;
  logic we;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  modport card(
    input card_reset_line_n, power_on, req, we, addr, wdata,
    output card_status_change_line, rdata, ack
  );
  modport sock(
    output card_reset_line_n, power_on, req, we, addr, wdata,
    input card_status_change_line, rdata, ack
  );
endinterface

// ==== design/scn_card.sv ====
// Purpose: Card end of status-change notification and wake-up
// Assumes: Status sources synchronous to i_sys_clk
// Notes on behaviour
// - Status line active high, level, own line
// - Four word registers at base plus 0,4,8,12
// - No line and registers: locator says zero
// - Powered off: idle low, one wake pulse
// - Option: hold wake high until power returns
// - Powered on: status change shown as level
// - Wake assertion lasts at least 1 ms
// - Host catches one shortest wake pulse
// - Host suppresses signalling through mask register
// - Host holds card reset over power-down
// - Host powers up with card reset held
// - Wake-capable card implements all four registers
// - Wake only with wake-enable and mask set
// - Wake fields survive power cycling and reset
// - Line high while masked status event set; code uses bits 0-3 only
// - Host clears events and owns the mask
// - Card with auxiliary power implements wake
// - No auxiliary power: no retention, no wake
// - Host ignores line during power cycling
// - Interrupt field wakes, never drives level
// - Writes to unimplemented fields are ignored
// - Present change sets event; one clears
// - Event bits 0-4 and 15 as laid out
`timescale 1ns/1ps
module scn_card
  import scn_pkg::*;
#(
  parameter logic [31:0] IMPL = SCN_IMPL_DEF,
  parameter bit HAS_AUX = 1'b1,
  parameter bit WAKE_HOLD = 1'b0,
  parameter int WAKE_CYC = SCN_WAKE_CYC,
  parameter bit HAS_REGS = 1'b1
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Status sources
  input wire logic i_wp,
  input wire logic i_ready,
  input wire logic [1:0] i_bvd,
  input wire logic i_general_wake_field,
  // Observation
  output logic [31:0] o_event_flags,
  output logic o_locator_space_nz,
  // Link
  scn_if.card lnk
);
  localparam int CW = $clog2(WAKE_CYC + 1);

  generate
    if (WAKE_CYC < 1)
    begin : g_bad_cyc
      $error("WAKE_CYC must be at least one");
    end
    if (HAS_AUX && !HAS_REGS)
    begin : g_bad_regs
      $error("Wake needs the register set");
    end
  endgenerate

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_PULSE = 3'b010,
    W_HOLD = 3'b100
  } scn_wake_t;

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] evt_q;
  logic [31:0] evt_d;
  logic [31:0] msk_q;
  logic [31:0] msk_d;
  logic [4:0] pst_q;
  logic pst_ok_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic line_q;
  logic wake_src_q;
  logic [CW-1:0] cnt_q;
  scn_wake_t wst_q;

  // Fields that can be written at all
  localparam logic [31:0] EVT_W = IMPL & SCN_EVT_FIELDS;
  localparam logic [31:0] MSK_W = IMPL;

  wire logic [4:0] pst_d = {i_general_wake_field, i_bvd[0], i_bvd[1],
                            i_ready, i_wp};
  wire logic take = lnk.req & ~ack_q;
  wire logic wr = take & lnk.we;
  wire logic wr_evt = wr & (lnk.addr == SCN_EVT_OFS);
  wire logic wr_msk = wr & (lnk.addr == SCN_MSK_OFS);
  wire logic wr_frc = wr & (lnk.addr == SCN_FRC_OFS);

  ////////////////////////////////////////////////////////////////////
  // Event detection
  // WP and battery fields on any change, ready and general wake
  // only on the rising edge
  wire logic [4:0] chg = {pst_d[4] & ~pst_q[4],
                          pst_d[3] ^ pst_q[3],
                          pst_d[2] ^ pst_q[2],
                          pst_d[1] & ~pst_q[1],
                          pst_d[0] ^ pst_q[0]};
  wire logic [31:0] ev_set =
    (({27'd0, chg} & {32{pst_ok_q}})
     | (wr_frc ? lnk.wdata : 32'h0000_0000)) & EVT_W;
  wire logic [31:0] ev_clr =
    wr_evt ? (lnk.wdata & EVT_W) : 32'h0000_0000;

  // Without auxiliary power nothing survives reset or power loss
  wire logic lose = ~HAS_AUX
    & (~lnk.card_reset_line_n | ~lnk.power_on);

  assign evt_d = lose ? SCN_REG_RESET
    : scn_w1c(evt_q, ev_set, ev_clr);
  assign msk_d = lose ? SCN_REG_RESET
    : wr_msk ? ((lnk.wdata & MSK_W) | (msk_q & ~MSK_W))
    : msk_q;

  ////////////////////////////////////////////////////////////////////
  // Read path
  wire logic [31:0] rd_mux =
    !HAS_REGS ? 32'h0000_0000 :
    (lnk.addr == SCN_EVT_OFS) ? evt_q :
    (lnk.addr == SCN_MSK_OFS) ? msk_q :
    (lnk.addr == SCN_PST_OFS) ? ({27'd0, pst_q} & EVT_W) :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////
  // Line drive
  wire logic on_mode = lnk.power_on & lnk.card_reset_line_n;
  // Interrupt request is left out of the level on purpose
  wire logic lvl = |(evt_q & msk_q & SCN_LVL_FIELDS);
  wire logic wake_src = HAS_AUX & msk_q[SCN_WKEN_BIT]
    & |(evt_q & msk_q & SCN_EVT_FIELDS);
  wire logic wake_rise = wake_src & ~wake_src_q;
  wire logic cnt_end = (cnt_q == CW'(1));

  scn_wake_t wst_d;
  logic [CW-1:0] cnt_d;

  always_comb
  begin
    wst_d = wst_q;
    cnt_d = cnt_q;
    unique case (wst_q)
      W_IDLE:
      begin
        if (!on_mode && wake_rise)
        begin
          wst_d = W_PULSE;
          cnt_d = CW'(WAKE_CYC);
        end
      end
      W_PULSE:
      begin
        cnt_d = cnt_q - CW'(1);
        if (on_mode)
          wst_d = W_IDLE;
        else if (cnt_end)
          wst_d = WAKE_HOLD ? W_HOLD : W_IDLE;
      end
      W_HOLD:
      begin
        if (on_mode)
          wst_d = W_IDLE;
      end
      default:
        wst_d = W_IDLE;
    endcase
  end

  // A short pulse is held out only until power returns, then the
  // level takes over the line
  wire logic line_d = on_mode ? lvl
    : (wst_d != W_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Flops: retained fields use only the card's own supply reset
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      evt_q <= SCN_REG_RESET;
      msk_q <= SCN_REG_RESET;
      pst_q <= 5'd0;
      pst_ok_q <= 1'b0;
    end
    else
    begin
      evt_q <= evt_d;
      msk_q <= msk_d;
      pst_q <= pst_d;
      pst_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= take;
      if (take)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wst_q <= W_IDLE;
      cnt_q <= '0;
      wake_src_q <= 1'b0;
      line_q <= 1'b0;
      o_event_flags <= SCN_REG_RESET;
      o_locator_space_nz <= 1'b0;
    end
    else
    begin
      wst_q <= wst_d;
      cnt_q <= cnt_d;
      wake_src_q <= wake_src;
      line_q <= line_d;
      o_event_flags <= evt_d;
      o_locator_space_nz <= HAS_REGS;
    end
  end

  assign lnk.card_status_change_line = line_q;
  assign lnk.ack = ack_q;
  assign lnk.rdata = rdata_q;
endmodule

// ==== design/scn_sock.sv ====
// Purpose: Socket end: power sequencing, wake capture, card access
// Assumes: AXI4-Lite master on the system side
// Notes: Card window answers only while the card is powered
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module scn_sock
  import scn_pkg::*;
#(
  parameter int RST_CYC = SCN_RST_CYC
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Notifications
  output logic o_wake,
  output logic o_status_irq,
  // Link
  scn_if.sock lnk
);
  localparam int RW = $clog2(RST_CYC + 1);
  generate
    if (RST_CYC < 1)
    begin : g_bad_rst
      $error("RST_CYC must be at least one");
    end
  endgenerate

  typedef enum logic [3:0] {
    P_OFF = 4'b0001, P_UP = 4'b0010, P_ON = 4'b0100, P_DOWN = 4'b1000
  } scn_pwr_t;
  typedef enum logic [3:0] {
    B_IDLE = 4'b0001, B_CARD = 4'b0010, B_WRSP = 4'b0100,
    B_RRSP = 4'b1000
  } scn_bus_t;

  scn_pwr_t pst_q;
  scn_bus_t bst_q;
  logic [RW-1:0] rcnt_q;
  logic pwr_q, card_reset_line_n_q, ctl_pwr_q, ctl_auto_q, wake_q, irq_q;
  logic lat_q, lat_s1_q, lat_s2_q, clr_q, lvl_s1_q, lvl_s2_q;
  logic aw_have_q, w_have_q, ar_have_q, is_wr_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic req_q, we_q;
  logic [3:0] caddr_q;

  ////////////////////////////////////////////////////////////////////
  // Line capture: a short pulse sets the latch even between clocks
  wire logic clr_n = i_rstn & ~clr_q;
  always_ff @(posedge lnk.card_status_change_line or negedge clr_n)
  begin
    if (!clr_n)
      lat_q <= 1'b0;
    else
      lat_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // Register decode
  wire logic [31:0] bmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}},
                             {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
  wire logic wr_go = (bst_q == B_IDLE) & aw_have_q & w_have_q;
  wire logic rd_go = (bst_q == B_IDLE) & ~wr_go & ar_have_q;
  wire logic [7:0] go_addr = wr_go ? awaddr_q : araddr_q;
  wire logic go_card = (go_addr[7:4] == SCN_H_CARD[7:4]);
  // A pending power-down refuses card work, so req never meets reset
  wire logic go_ok = go_card ? (pst_q == P_ON) & ctl_pwr_q
    : (go_addr == SCN_H_CTRL) | (go_addr == SCN_H_STAT);
  wire logic wr_ctrl = wr_go & (awaddr_q == SCN_H_CTRL);
  wire logic wr_stat = wr_go & (awaddr_q == SCN_H_STAT);
  wire logic [31:0] stat_word = {27'd0, ~card_reset_line_n_q, pwr_q,
                                 irq_q, 1'b0, wake_q};
  wire logic [31:0] loc_rd = (araddr_q == SCN_H_CTRL)
    ? {30'd0, ctl_auto_q, ctl_pwr_q}
    : (araddr_q == SCN_H_STAT) ? stat_word : 32'h0000_0000;
  // Activity while power ramps is neither wake nor interrupt
  wire logic got_wake = lat_s2_q & (pst_q == P_OFF);
  wire logic rcnt_end = (rcnt_q == '0);

  ////////////////////////////////////////////////////////////////////
  // Synchronisers and notification flags
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {lat_s1_q, lat_s2_q, clr_q} <= 3'b000;
      {lvl_s1_q, lvl_s2_q} <= 2'b00;
      {wake_q, irq_q, o_wake, o_status_irq} <= 4'b0000;
    end
    else
    begin
      lat_s1_q <= lat_q;
      lat_s2_q <= lat_s1_q;
      clr_q <= lat_s2_q;
      lvl_s1_q <= lnk.card_status_change_line;
      lvl_s2_q <= lvl_s1_q;
      // Write data may be gone by the decode cycle; use the held copy
      wake_q <= got_wake | (wake_q & ~(wr_stat & wdata_q[0]));
      irq_q <= lvl_s2_q & (pst_q == P_ON);
      o_wake <= wake_q;
      o_status_irq <= irq_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power and card reset sequencing
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pst_q <= P_OFF;
      pwr_q <= 1'b0;
      card_reset_line_n_q <= 1'b0;
      rcnt_q <= '0;
      ctl_pwr_q <= 1'b0;
      ctl_auto_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        {ctl_auto_q, ctl_pwr_q} <= wdata_q[1:0];
      // A wake in the same cycle as a write still requests power
      if (got_wake && ctl_auto_q)
        ctl_pwr_q <= 1'b1;
      if (!rcnt_end)
        rcnt_q <= rcnt_q - RW'(1);
      unique case (pst_q)
        P_OFF:
          if (ctl_pwr_q)
          begin
            pst_q <= P_UP;
            pwr_q <= 1'b1;
            rcnt_q <= RW'(RST_CYC);
          end
        P_UP:
          if (rcnt_end)
          begin
            pst_q <= P_ON;
            card_reset_line_n_q <= 1'b1;
          end
        P_ON:
          if (!ctl_pwr_q && bst_q == B_IDLE)
          begin
            pst_q <= P_DOWN;
            card_reset_line_n_q <= 1'b0;
            rcnt_q <= RW'(RST_CYC);
          end
        P_DOWN:
          if (rcnt_end)
          begin
            pst_q <= P_OFF;
            pwr_q <= 1'b0;
          end
        default:
          pst_q <= P_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and card access
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bst_q <= B_IDLE;
      {aw_have_q, w_have_q, ar_have_q, is_wr_q} <= 4'b0000;
      {o_awready, o_wready, o_arready} <= 3'b111;
      {o_bvalid, o_rvalid, req_q, we_q} <= 4'b0000;
      {awaddr_q, araddr_q} <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      caddr_q <= 4'h0;
      o_rdata <= 32'h0000_0000;
      o_bresp <= SCN_OKAY;
      o_rresp <= SCN_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= i_wdata & bmask;
        o_wready <= 1'b0;
      end
      if (i_arvalid && o_arready)
      begin
        ar_have_q <= 1'b1;
        araddr_q <= i_araddr;
        o_arready <= 1'b0;
      end
      unique case (bst_q)
        B_IDLE:
          if (wr_go || rd_go)
          begin
            is_wr_q <= wr_go;
            if (go_card && go_ok)
            begin
              bst_q <= B_CARD;
              req_q <= 1'b1;
              we_q <= wr_go;
              caddr_q <= go_addr[3:0];
            end
            else if (wr_go)
            begin
              bst_q <= B_WRSP;
              o_bvalid <= 1'b1;
              o_bresp <= go_ok ? SCN_OKAY : SCN_SLVERR;
            end
            else
            begin
              bst_q <= B_RRSP;
              o_rvalid <= 1'b1;
              o_rdata <= loc_rd;
              o_rresp <= go_ok ? SCN_OKAY : SCN_SLVERR;
            end
          end
        B_CARD:
          if (lnk.ack)
          begin
            req_q <= 1'b0;
            bst_q <= is_wr_q ? B_WRSP : B_RRSP;
            o_bvalid <= is_wr_q;
            o_rvalid <= ~is_wr_q;
            o_rdata <= lnk.rdata;
            o_bresp <= SCN_OKAY;
            o_rresp <= SCN_OKAY;
          end
        B_WRSP:
          if (i_bready)
          begin
            o_bvalid <= 1'b0;
            {aw_have_q, w_have_q} <= 2'b00;
            {o_awready, o_wready} <= 2'b11;
            bst_q <= B_IDLE;
          end
        B_RRSP:
          if (i_rready)
          begin
            o_rvalid <= 1'b0;
            ar_have_q <= 1'b0;
            o_arready <= 1'b1;
            bst_q <= B_IDLE;
          end
        default:
          bst_q <= B_IDLE;
      endcase
    end
  end

  assign lnk.power_on = pwr_q;
  assign lnk.card_reset_line_n = card_reset_line_n_q;
  assign lnk.req = req_q;
  assign lnk.we = we_q;
  assign lnk.addr = caddr_q;
  assign lnk.wdata = wdata_q;
endmodule

// ==== bench/scn_monitor.sv ====
// Purpose: Checker for the card-socket status-change link
// Assumes: One clock, WAKE_CYC equal to the card's
// Notes: Sees the link only; register effects are judged by the bench
`timescale 1ns/1ps
module scn_monitor #(
  parameter int WAKE_CYC = 40000
)(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Link
  input wire logic card_status_change_line,
  input wire logic card_reset_line_n,
  input wire logic power_on,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack
);
  // High cycles of the line before this one; pulse length needs a count
  logic [15:0] hi_cnt_q;
  logic [15:0] hi_cnt_d;
  assign hi_cnt_d = card_status_change_line ? hi_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      hi_cnt_q <= 16'h0000;
    else
      hi_cnt_q <= hi_cnt_d;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("card request changed before its ack");
  property p_ack_soon;
    $rose(req) |-> ##[1:3] ack;
  endproperty
  a_ack_soon: assert property (p_ack_soon)
    else $error("card did not ack in time");
  property p_ack_pulse;
    ack |-> req ##1 !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack without request or longer than one cycle");
  property p_req_powered;
    req |-> power_on && card_reset_line_n;
  endproperty
  a_req_powered: assert property (p_req_powered)
    else $error("card access while not powered");
  property p_rst_first;
    $fell(power_on) |-> !$past(card_reset_line_n, 2);
  endproperty
  a_rst_first: assert property (p_rst_first)
    else $error("power removed without card reset held");
  property p_rst_pwr;
    card_reset_line_n |-> power_on;
  endproperty
  a_rst_pwr: assert property (p_rst_pwr)
    else $error("card reset released while unpowered");
  property p_rst_up;
    $rose(power_on) |-> !card_reset_line_n [*4];
  endproperty
  a_rst_up: assert property (p_rst_up)
    else $error("card reset not held during power-up");
  property p_wake_len;
    $fell(card_status_change_line) && !power_on |-> hi_cnt_q >= WAKE_CYC;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake pulse too short");
  property p_wake_once;
    !power_on && card_status_change_line |-> hi_cnt_q < WAKE_CYC;
  endproperty
  a_wake_once: assert property (p_wake_once)
    else $error("wake pulse too long while unpowered");
  c_wake: cover property ($fell(card_status_change_line) && !power_on);
  c_card_wr: cover property (req && we && ack);
  c_card_rd: cover property (req && !we && ack);
  c_pwr_up: cover property ($rose(card_reset_line_n));
endmodule

// ==== bench/status_change_wakeup_notify_bench.sv ====
// Purpose: Self-checking bench for both status-change notify ends
// Assumes: Socket reached over AXI4-Lite, card window at 0x10
// Notes: Short wake pulse and reset counts keep the run small
`timescale 1ns/1ps
module status_change_wakeup_notify_bench
  import scn_pkg::*;
;
  localparam int WCYC = 20;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wake, irq, loc;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, evf;
  logic [1:0] bresp, rresp;
  logic [4:0] src;
  int errors, n_compared;
  scn_if lnk();
  scn_card #(.WAKE_CYC(WCYC)) u_scn_card (.i_sys_clk(clk), .i_rstn(rstn),
    .i_wp(src[0]), .i_ready(src[1]), .i_bvd({src[2], src[3]}),
    .i_general_wake_field(src[4]), .o_event_flags(evf), .o_locator_space_nz(loc),
    .lnk(lnk));
  scn_sock #(.RST_CYC(4)) u_scn_sock (.i_sys_clk(clk), .i_rstn(rstn),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .o_wake(wake), .o_status_irq(irq), .lnk(lnk));
  scn_monitor #(.WAKE_CYC(WCYC)) u_scn_monitor (.i_sys_clk(clk),
    .i_rstn(rstn), .card_status_change_line(lnk.card_status_change_line),
    .card_reset_line_n(lnk.card_reset_line_n), .power_on(lnk.power_on),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata),
    .ack(lnk.ack));
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chl(input logic e);
    chk("status line", {31'h0, lnk.card_status_change_line}, {31'h0, e});
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid === 1'h1 && awready === 1'h1)
        awvalid <= 1'h0;
      if (wvalid === 1'h1 && wready === 1'h1)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid === 1'h1 && arready === 1'h1)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", rdata, e);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // Waits on the link, not a fixed count, since sequencing may vary
  task automatic pwr(input logic on, input logic [31:0] es);
    axw(SCN_H_CTRL, {31'h0, on}, SCN_OKAY);
    for (int k = 0; k < 100; k++)
    begin
      if (lnk.power_on === on && lnk.card_reset_line_n === on &&
          irq === es[2])
        break;
      @(posedge clk);
    end
    axr(SCN_H_STAT, es, SCN_OKAY);
  endtask
  task automatic t_refuse();
    axr(SCN_H_STAT, 32'h0000_0010, SCN_OKAY);
    axr(8'h10, 32'h0000_0000, SCN_SLVERR);
    axr(8'h40, 32'h0000_0000, SCN_SLVERR);
    axw(8'h40, 32'h0000_0001, SCN_SLVERR);
    chk("locator", {31'h0, loc}, 32'h0000_0001);
  endtask
  task automatic t_regs();
    pwr(1'h1, 32'h0000_0008);
    axw(8'h14, 32'hffff_ffff, SCN_OKAY);
    axr(8'h14, SCN_IMPL_DEF, SCN_OKAY);
    axr(8'h1c, 32'h0000_0000, SCN_OKAY);
    src <= 5'h0d;
    axr(8'h18, 32'h0000_000d, SCN_OKAY);
    axr(8'h10, 32'h0000_000d, SCN_OKAY);
    chl(1'h1);
    src <= 5'h00;
    axw(8'h10, 32'h0000_801f, SCN_OKAY);
    axr(8'h10, 32'h0000_0000, SCN_OKAY);
    chk("event flags", evf, 32'h0000_0000);
    chl(1'h0);
  endtask
  task automatic t_events();
    for (int i = 0; i < 4; i++)
    begin
      axw(8'h14, 32'h0000_0001 << i, SCN_OKAY);
      src[i] <= 1'h1;
      axr(8'h10, 32'h0000_0001 << i, SCN_OKAY);
      for (int k = 0; k < 10 && irq !== 1'h1; k++)
        @(posedge clk);
      chl(1'h1);
      chk("status irq", {31'h0, irq}, 32'h0000_0001);
      axw(8'h10, 32'h0000_0001 << i, SCN_OKAY);
      axr(8'h10, 32'h0000_0000, SCN_OKAY);
      chl(1'h0);
      src[i] <= 1'h0;
      // Ready counts only busy to ready, so its fall leaves no event
      axr(8'h10, i == 1 ? 32'h0 : 32'h0000_0001 << i, SCN_OKAY);
      axw(8'h10, 32'h0000_001f, SCN_OKAY);
    end
  endtask
  task automatic t_mask_interrupt_request_field();
    axw(8'h14, 32'h0000_0000, SCN_OKAY);
    src[0] <= 1'h1;
    axr(8'h10, 32'h0000_0001, SCN_OKAY);
    chl(1'h0);
    axw(8'h14, 32'h0000_801f, SCN_OKAY);
    axw(8'h1c, 32'h0000_8000, SCN_OKAY);
    axr(8'h10, 32'h0000_8001, SCN_OKAY);
    chl(1'h1);
    axw(8'h10, 32'h0000_0001, SCN_OKAY);
    src[4] <= 1'h1;
    axr(8'h10, 32'h0000_8010, SCN_OKAY);
    chl(1'h0);
    src[4] <= 1'h0;
    axw(8'h10, 32'h0000_801f, SCN_OKAY);
    axr(8'h10, 32'h0000_0000, SCN_OKAY);
  endtask
  task automatic t_wake();
    int n;
    axw(8'h14, 32'h0000_0001, SCN_OKAY);
    pwr(1'h0, 32'h0000_0010);
    src[0] <= ~src[0];
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      n += int'(lnk.card_status_change_line === 1'h1);
    end
    chk("pulses without enable", 32'(n), 32'h0000_0000);
    chk("wake", {31'h0, wake}, 32'h0000_0000);
    pwr(1'h1, 32'h0000_000c);
    axr(8'h10, 32'h0000_0001, SCN_OKAY);
    axr(8'h14, 32'h0000_0001, SCN_OKAY);
    axw(8'h14, 32'h0000_4001, SCN_OKAY);
    axw(8'h10, 32'h0000_0001, SCN_OKAY);
    pwr(1'h0, 32'h0000_0010);
    src[0] <= ~src[0];
    for (int k = 0; k < 60 && lnk.card_status_change_line !== 1'h1; k++)
      @(posedge clk);
    for (n = 0; n < 100 && lnk.card_status_change_line === 1'h1; n++)
      @(posedge clk);
    chk("wake pulse length", 32'(n), 32'(WCYC));
    chk("wake", {31'h0, wake}, 32'h0000_0001);
    axr(SCN_H_STAT, 32'h0000_0011, SCN_OKAY);
    axw(SCN_H_STAT, 32'h0000_0001, SCN_OKAY);
    axr(SCN_H_STAT, 32'h0000_0010, SCN_OKAY);
    // Auto power-up: the wake pulse hands over to the level
    pwr(1'h1, 32'h0000_000c);
    axw(8'h10, 32'h0000_0001, SCN_OKAY);
    axw(SCN_H_CTRL, 32'h0000_0002, SCN_OKAY);
    for (int k = 0; k < 60 && lnk.power_on !== 1'h0; k++)
      @(posedge clk);
    src[0] <= ~src[0];
    for (int k = 0; k < 200 && lnk.card_reset_line_n !== 1'h1; k++)
      @(posedge clk);
    chk("auto power", {31'h0, lnk.power_on}, 32'h0000_0001);
    chl(1'h1);
    axr(SCN_H_STAT, 32'h0000_000d, SCN_OKAY);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    rstn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    src = 5'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    t_refuse();
    t_regs();
    t_events();
    t_mask_interrupt_request_field();
    t_wake();
    tally_and_finish();
  end
endmodule
